// >>> testbench/asp_remote_node.sv
`timescale 1ns/100ps
`default_nettype none
module asp_remote_node #(parameter int BIT = 32) (
    input wire logic clk_i,
    input wire logic txd_i,
    output logic rxd_o,
    output logic [10:0] cap_o,
    output logic [7:0] cnt_o
);
    // ==========
    // Sender; the line rests at the marking level between frames
    initial
    begin
        rxd_o = 1'b1;
        cap_o = '0;
        cnt_o = '0;
    end
    // A short bit length makes a glitch rather than a real bit
    task automatic send(input logic [10:0] f, input int n, input int len);
        for (int i = 0; i < n; i++)
        begin
            rxd_o <= f[i];
            repeat (len) @(posedge clk_i);
        end
        rxd_o <= 1'b1;
    endtask : send
    // ==========
    // Mid-bit sampler; always 11 bits, the last is idle in 10-bit frames
    always
    begin
        @(negedge txd_i);
        repeat (BIT / 2) @(posedge clk_i);
        for (int i = 0; i < 11; i++)
        begin
            cap_o[i] <= txd_i;
            repeat (BIT) @(posedge clk_i);
        end
        cnt_o <= cnt_o + 8'h01;
    end
endmodule : asp_remote_node
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // Two clocks per 16x tick, so one bit is 32 clocks
    localparam int BIT = 32;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] awaddr = '0, araddr = '0, cnt;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, tick = 0;
    logic [31:0] wdata = '0, rdata, r;
    logic [3:0] strb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, txd, rxd, irq;
    logic [1:0] bresp, rresp;
    logic [10:0] cap;
    int n_mismatch = 0, compares = 0, cyc = 0;
    always #4 clk_i = ~clk_i;
    asp_serial_port dut (.clk_i(clk_i), .reset_i(reset_i), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(strb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .timer1_ovf_i(tick), .timer2_ovf_i(tick),
        .rxd_i(rxd), .txd_o(txd), .serial_irq_o(irq));
    asp_remote_node #(.BIT(BIT)) node (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd),
        .cap_o(cap), .cnt_o(cnt));
    // ==========
    // Helpers
    task automatic tally_and_finish();
        if (n_mismatch == 0 && compares > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] br);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end
        while (!bvalid);
        br = bresp;
        bready <= 1'b0;
        @(posedge clk_i);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rr);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge clk_i);
            if (arready)
                arvalid <= 1'b0;
        end
        while (!rvalid);
        d = rdata;
        rr = rresp;
        rready <= 1'b0;
        @(posedge clk_i);
    endtask : rd
    function automatic logic [10:0] frm(logic [7:0] d, logic n9, logic ten);
        return ten ? {2'b11, d, 1'b0} : {1'b1, n9, d, 1'b0};
    endfunction : frm
    function automatic logic [31:0] ctl(logic [1:0] m, logic f, logic n9);
        return {24'h0, m, f, 1'b1, n9, 3'h0};
    endfunction : ctl
    // ==========
    // Tick source and hang guard
    always @(posedge clk_i)
    begin
        tick <= ~tick;
        cyc++;
        if (cyc > 20000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    // ==========
    // Main sequence
    initial
    begin
        logic [1:0] rr, m;
        logic [7:0] d, be, c0;
        logic n9, ten, f, st, acc, ne;
        logic [10:0] fr;
        logic [31:0] ex;
        r = $urandom(28);
        repeat (10) @(posedge clk_i);
        reset_i <= 1'b0;
        rd(asp_pkg::ADDR_CTRL, r, rr);
        chk("ctrl reset", 32'h40, r);
        rd(asp_pkg::ADDR_RATE, r, rr);
        chk("rate reset", 32'h0, r);
        rd(8'h0c, r, rr);
        chk("rd resp", {30'h0, asp_pkg::RESP_SLVERR}, {30'h0, rr});
        wr(8'h0c, 32'h0, rr);
        chk("wr resp", {30'h0, asp_pkg::RESP_SLVERR}, {30'h0, rr});
        strb <= 4'h0;
        wr(asp_pkg::ADDR_RATE, 32'h7, rr);
        strb <= 4'hf;
        rd(asp_pkg::ADDR_RATE, r, rr);
        chk("masked write", 32'h0, r);
        for (int k = 0; k < 6; k++)
        begin
            m = (k < 2) ? asp_pkg::MODE_10BIT : (k == 4) ? asp_pkg::MODE_FIXED
                : (k == 5) ? 2'h0 : asp_pkg::MODE_VAR;
            d = (k == 0) ? 8'hff : (k == 1) ? 8'h00 : 8'($urandom);
            n9 = 1'($urandom);
            ten = !m[1];
            wr(asp_pkg::ADDR_RATE, (k == 3) ? 32'h1 : 32'h7, rr);
            wr(asp_pkg::ADDR_CTRL, ctl(m, 1'b0, n9), rr);
            c0 = cnt;
            wr(asp_pkg::ADDR_DATA, {24'h0, d}, rr);
            while (cnt == c0)
                @(posedge clk_i);
            ex = {21'h0, frm(d, n9, ten)};
            chk("tx frame", ex, {21'h0, cap});
            chk("irq", 32'h1, {31'h0, irq});
            rd(asp_pkg::ADDR_CTRL, r, rr);
            chk("tx done", ctl(m, 1'b0, n9) | 32'h2, r);
            wr(asp_pkg::ADDR_CTRL, ctl(m, 1'b0, n9), rr);
            chk("irq clear", 32'h0, {31'h0, irq});
        end
        wr(asp_pkg::ADDR_CTRL, ctl(asp_pkg::MODE_10BIT, 1'b0, 1'b0), rr);
        node.send(11'h0, 1, 6);
        repeat (12 * BIT) @(posedge clk_i);
        rd(asp_pkg::ADDR_CTRL, r, rr);
        chk("false start", ctl(asp_pkg::MODE_10BIT, 1'b0, 1'b0), r);
        be = '0;
        ne = 1'b0;
        for (int k = 0; k < 6; k++)
        begin
            ten = (k < 2);
            m = ten ? asp_pkg::MODE_10BIT : asp_pkg::MODE_VAR;
            f = (k >= 1 && k <= 3);
            n9 = (k == 3);
            st = !(k == 1 || k == 3);
            d = 8'($urandom);
            fr = ten ? {1'b0, st, d, 1'b0} : {st, n9, d, 1'b0};
            acc = (k != 5) && (!f || (ten ? st : n9));
            if (k != 5)
            begin
                wr(asp_pkg::ADDR_CTRL, ctl(m, f, 1'b0), rr);
                ne = 1'b0;
            end
            node.send(fr, ten ? 10 : 11, BIT);
            repeat (BIT / 2) @(posedge clk_i);
            if (acc)
            begin
                be = d;
                ne = ten ? st : n9;
            end
            rd(asp_pkg::ADDR_CTRL, r, rr);
            ex = ctl(m, f, 1'b0) | {29'h0, ne, 1'b0, acc || k == 5};
            chk("rx flags", ex, r);
            rd(asp_pkg::ADDR_DATA, r, rr);
            chk("rx buffer", {24'h0, be}, r);
        end
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire

// >>> verilog/asp_pkg.sv
`default_nettype none
package asp_pkg;
    // ==========================================================
    // Register map, byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_DATA = 8'h04;
    localparam logic [7:0] ADDR_RATE = 8'h08;
    // ==========================================================
    // Serial control field positions
    localparam int CTRL_RX_DONE = 0;
    localparam int CTRL_TX_DONE = 1;
    localparam int CTRL_RX_NINTH = 2;
    localparam int CTRL_TX_NINTH = 3;
    localparam int CTRL_RX_EN = 4;
    localparam int CTRL_FILTER = 5;
    localparam int CTRL_MODE = 6;
    // ==========================================================
    // Rate control field positions
    localparam int RATE_DOUBLE = 0;
    localparam int RATE_TX_SEL = 1;
    localparam int RATE_RX_SEL = 2;
    // ==========================================================
    // Frame modes
    localparam logic [1:0] MODE_10BIT = 2'h1;
    localparam logic [1:0] MODE_FIXED = 2'h2;
    localparam logic [1:0] MODE_VAR = 2'h3;
    // ==========================================================
    // Timing counts
    localparam logic [3:0] CNT_LAST = 4'hf;
    localparam logic [3:0] SMP_A = 4'h7;
    localparam logic [3:0] SMP_B = 4'h8;
    localparam logic [3:0] SMP_C = 4'h9;
    localparam logic [1:0] FIXED_LIM_FAST = 2'h1;
    localparam logic [1:0] FIXED_LIM_SLOW = 2'h3;
    localparam logic [3:0] TX_BITS_10 = 4'ha;
    localparam logic [3:0] TX_BITS_11 = 4'hb;
    // ==========================================================
    // Shift register patterns
    localparam logic [8:0] RX_PRESET = 9'h1ff;
    localparam logic [7:0] TX_MARK = 8'h01;
    // ==========================================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================================
    // State
    typedef enum logic [1:0] {RX_HUNT, RX_BIT, RX_STOP} asp_rx_e;
    typedef struct packed {
        logic aw_got; logic w_got; logic [7:0] aw_addr; logic [7:0] w_data; logic w_strb0;
        logic bvalid; logic [1:0] bresp; logic rvalid; logic [7:0] rdata; logic [1:0] rresp;
        logic rx_done; logic tx_done; logic rx_ninth; logic tx_ninth; logic rx_en;
        logic filter; logic [1:0] mode; logic dbl; logic tx_t2; logic rx_t2;
        logic [1:0] tx_pre; logic [3:0] tx_cnt; logic tx_req; logic tx_send; logic tx_data_on;
        logic tx_first; logic [8:0] tx_sr; logic txd; logic [3:0] tx_bits;
        logic [1:0] rx_pre; logic [3:0] rx_cnt; logic [2:0] sync; logic rx_line; logic rx_prev;
        asp_rx_e rx_state; logic [8:0] rx_sr; logic [2:0] rx_smp; logic [7:0] rx_buf;
    } asp_st_s;
    localparam asp_st_s ST_RESET = '{txd: 1'b1, sync: 3'h7, rx_line: 1'b1, rx_prev: 1'b1,
        rx_state: RX_HUNT, mode: MODE_10BIT, default: '0};
endpackage : asp_pkg
`default_nettype wire

// >>> verilog/asp_serial_port.sv
// The implementer's own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module asp_serial_port (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic timer1_ovf_i,
    input wire logic timer2_ovf_i,
    input wire logic rxd_i,
    output logic txd_o,
    output logic serial_irq_o
);
    asp_pkg::asp_st_s st;
    asp_pkg::asp_st_s next_st;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_data;
    logic wr_rate;
    logic ten_bit;
    logic tx_tick;
    logic tx_roll;
    logic rx_tick;
    logic rx_roll;
    logic rx_fall;
    logic rx_vote;
    logic rx_final;
    logic rx_load;
    logic [2:0] tx_rate;
    logic [2:0] rx_rate;

    // ==========================================================
    // Helpers
    // Returns {tick, next prescale}; tick is the 16x sample strobe
    function automatic logic [2:0] rate_tick(input logic [1:0] pre, input logic use_t2,
        input logic [1:0] mode, input logic dbl, input logic t1, input logic t2);
        logic [2:0] r;
        logic [1:0] lim;
        r = {1'b0, pre};
        lim = dbl ? asp_pkg::FIXED_LIM_FAST : asp_pkg::FIXED_LIM_SLOW;
        if (mode == asp_pkg::MODE_FIXED)
        begin
            r = (pre >= lim) ? 3'h4 : {1'b0, pre + 2'h1};
        end
        else if (use_t2)
        begin
            r = {t2, 2'h0};
        end
        else if (t1)
        begin
            r = (dbl || pre[0]) ? 3'h4 : 3'h1;
        end
        return r;
    endfunction : rate_tick

    // First received bit lands leftmost, so the byte comes out mirrored
    function automatic logic [7:0] mirror8(input logic [7:0] v);
        logic [7:0] r;
        r = 8'h00;
        for (int i = 0; i < 8; i++)
        begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction : mirror8

    // ==========================================================
    // Bus handshakes
    assign s_axi_awready_o = !st.aw_got && !st.bvalid;
    assign s_axi_wready_o = !st.w_got && !st.bvalid;
    assign s_axi_bvalid_o = st.bvalid;
    assign s_axi_bresp_o = st.bresp;
    assign s_axi_arready_o = !st.rvalid;
    assign s_axi_rvalid_o = st.rvalid;
    assign s_axi_rresp_o = st.rresp;
    assign s_axi_rdata_o = {24'h000000, st.rdata};
    assign txd_o = st.txd;
    assign serial_irq_o = st.rx_done || st.tx_done;

    assign wr_fire = st.aw_got && st.w_got && !st.bvalid;
    assign wr_ctrl = wr_fire && st.w_strb0 && (st.aw_addr == asp_pkg::ADDR_CTRL);
    assign wr_data = wr_fire && st.w_strb0 && (st.aw_addr == asp_pkg::ADDR_DATA);
    assign wr_rate = wr_fire && st.w_strb0 && (st.aw_addr == asp_pkg::ADDR_RATE);
    // Mode 0 is not built; it runs as the 10-bit frame
    assign ten_bit = (st.mode != asp_pkg::MODE_FIXED) && (st.mode != asp_pkg::MODE_VAR);

    // ==========================================================
    // Rate strobes
    assign tx_rate = rate_tick(st.tx_pre, st.tx_t2, st.mode, st.dbl, timer1_ovf_i, timer2_ovf_i);
    assign rx_rate = rate_tick(st.rx_pre, st.rx_t2, st.mode, st.dbl, timer1_ovf_i, timer2_ovf_i);
    assign tx_tick = tx_rate[2];
    assign rx_tick = rx_rate[2];
    assign tx_roll = tx_tick && (st.tx_cnt == asp_pkg::CNT_LAST);
    assign rx_roll = rx_tick && (st.rx_cnt == asp_pkg::CNT_LAST);
    assign rx_fall = rx_tick && st.rx_prev && !st.rx_line;
    assign rx_vote = (st.rx_smp[0] && st.rx_smp[1]) || (st.rx_smp[0] && st.rx_smp[2])
        || (st.rx_smp[1] && st.rx_smp[2]);
    assign rx_final = (st.rx_state == asp_pkg::RX_BIT) && rx_roll && !st.rx_sr[8];
    // Stop bit in 10-bit mode, ninth bit otherwise: both are the final vote
    assign rx_load = rx_final && !st.rx_done && (!st.filter || rx_vote);

    // ==========================================================
    // Next state
    always_comb
    begin
        next_st = st;
        if (s_axi_awvalid_i && s_axi_awready_o)
        begin
            next_st.aw_got = 1'b1;
            next_st.aw_addr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && s_axi_wready_o)
        begin
            next_st.w_got = 1'b1;
            next_st.w_data = s_axi_wdata_i[7:0];
            next_st.w_strb0 = s_axi_wstrb_i[0];
        end
        if (st.bvalid && s_axi_bready_i)
        begin
            next_st.bvalid = 1'b0;
        end
        if (wr_fire)
        begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = (st.aw_addr == asp_pkg::ADDR_CTRL || st.aw_addr == asp_pkg::ADDR_DATA
                || st.aw_addr == asp_pkg::ADDR_RATE) ? asp_pkg::RESP_OKAY : asp_pkg::RESP_SLVERR;
        end
        if (st.rvalid && s_axi_rready_i)
        begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid_i && s_axi_arready_o)
        begin
            next_st.rvalid = 1'b1;
            next_st.rresp = asp_pkg::RESP_OKAY;
            case (s_axi_araddr_i)
                asp_pkg::ADDR_CTRL: next_st.rdata = {st.mode, st.filter, st.rx_en, st.tx_ninth,
                    st.rx_ninth, st.tx_done, st.rx_done};
                asp_pkg::ADDR_DATA: next_st.rdata = st.rx_buf;
                asp_pkg::ADDR_RATE: next_st.rdata = {5'h00, st.rx_t2, st.tx_t2, st.dbl};
                default:
                begin
                    next_st.rdata = 8'h00;
                    next_st.rresp = asp_pkg::RESP_SLVERR;
                end
            endcase
        end
        // Software writes come first so that a hardware set in the same cycle wins
        if (wr_ctrl)
        begin
            next_st.rx_done = st.w_data[asp_pkg::CTRL_RX_DONE];
            next_st.tx_done = st.w_data[asp_pkg::CTRL_TX_DONE];
            next_st.rx_ninth = st.w_data[asp_pkg::CTRL_RX_NINTH];
            next_st.tx_ninth = st.w_data[asp_pkg::CTRL_TX_NINTH];
            next_st.rx_en = st.w_data[asp_pkg::CTRL_RX_EN];
            next_st.filter = st.w_data[asp_pkg::CTRL_FILTER];
            next_st.mode = st.w_data[asp_pkg::CTRL_MODE +: 2];
        end
        if (wr_rate)
        begin
            next_st.dbl = st.w_data[asp_pkg::RATE_DOUBLE];
            next_st.tx_t2 = st.w_data[asp_pkg::RATE_TX_SEL];
            next_st.rx_t2 = st.w_data[asp_pkg::RATE_RX_SEL];
        end

        // ======================================================
        // Transmitter
        next_st.tx_pre = tx_rate[1:0];
        if (tx_tick)
        begin
            next_st.tx_cnt = st.tx_cnt + 4'h1;
        end
        // A write during a frame is dropped; the shifter is not double-buffered
        if (wr_data && !st.tx_req && !st.tx_send)
        begin
            next_st.tx_sr = {ten_bit ? 1'b1 : st.tx_ninth, st.w_data};
            next_st.tx_req = 1'b1;
        end
        if (tx_roll)
        begin
            if (!st.tx_send)
            begin
                if (st.tx_req)
                begin
                    next_st.tx_send = 1'b1;
                    next_st.tx_req = 1'b0;
                    next_st.tx_data_on = 1'b0;
                    next_st.tx_first = 1'b0;
                    next_st.tx_bits = 4'h1;
                end
            end
            else if (!st.tx_data_on)
            begin
                next_st.tx_data_on = 1'b1;
                next_st.tx_bits = st.tx_bits + 4'h1;
            end
            else if (st.tx_first && st.tx_sr[8:1] == asp_pkg::TX_MARK)
            begin
                next_st.tx_sr = {1'b0, st.tx_sr[8:1]};
                next_st.tx_send = 1'b0;
                next_st.tx_data_on = 1'b0;
                next_st.tx_done = 1'b1;
                next_st.tx_bits = st.tx_bits + 4'h1;
            end
            else
            begin
                next_st.tx_sr = {!st.tx_first && !ten_bit, st.tx_sr[8:1]};
                next_st.tx_first = 1'b1;
                next_st.tx_bits = st.tx_bits + 4'h1;
            end
        end
        next_st.txd = !next_st.tx_send ? 1'b1 : (!next_st.tx_data_on ? 1'b0 : next_st.tx_sr[0]);

        // ======================================================
        // Receiver
        next_st.rx_pre = rx_rate[1:0];
        next_st.sync = {st.sync[1:0], rxd_i};
        if (st.sync[1] == st.sync[2])
        begin
            next_st.rx_line = st.sync[2];
        end
        if (rx_tick)
        begin
            next_st.rx_cnt = st.rx_cnt + 4'h1;
            next_st.rx_prev = st.rx_line;
        end
        case (st.rx_state)
            asp_pkg::RX_HUNT:
            begin
                if (rx_fall && st.rx_en)
                begin
                    next_st.rx_state = asp_pkg::RX_BIT;
                    next_st.rx_cnt = 4'h0;
                    next_st.rx_sr = asp_pkg::RX_PRESET;
                end
            end
            asp_pkg::RX_BIT:
            begin
                if (rx_tick && st.rx_cnt == asp_pkg::SMP_A)
                begin
                    next_st.rx_smp[0] = st.rx_line;
                end
                if (rx_tick && st.rx_cnt == asp_pkg::SMP_B)
                begin
                    next_st.rx_smp[1] = st.rx_line;
                end
                if (rx_tick && st.rx_cnt == asp_pkg::SMP_C)
                begin
                    next_st.rx_smp[2] = st.rx_line;
                end
                if (rx_roll)
                begin
                    next_st.rx_sr = {st.rx_sr[7:0], rx_vote};
                    if (st.rx_sr == asp_pkg::RX_PRESET && rx_vote)
                    begin
                        next_st.rx_state = asp_pkg::RX_HUNT;
                    end
                    else if (rx_final)
                    begin
                        // 11-bit modes sit out the stop bit, its value unused
                        next_st.rx_state = ten_bit ? asp_pkg::RX_HUNT : asp_pkg::RX_STOP;
                    end
                end
            end
            asp_pkg::RX_STOP:
            begin
                if (rx_roll)
                begin
                    next_st.rx_state = asp_pkg::RX_HUNT;
                end
            end
            default: next_st.rx_state = asp_pkg::RX_HUNT;
        endcase
        if (rx_load)
        begin
            next_st.rx_buf = mirror8(st.rx_sr[7:0]);
            next_st.rx_ninth = rx_vote;
            next_st.rx_done = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            st <= asp_pkg::ST_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (reset_i);

    property p_tx_start;
        tx_roll && st.tx_req && !st.tx_send |=> st.tx_send && !st.txd;
    endproperty
    a_tx_start: assert property (p_tx_start) else $error("start bit not driven at rollover");

    property p_tx_data_on;
        tx_roll && st.tx_send && !st.tx_data_on |=> st.tx_data_on && st.txd == st.tx_sr[0];
    endproperty
    a_tx_data_on: assert property (p_tx_data_on) else $error("data not enabled after start");

    property p_tx_len;
        $fell(st.tx_send) |-> st.tx_done && st.txd
            && st.tx_bits == (ten_bit ? asp_pkg::TX_BITS_10 : asp_pkg::TX_BITS_11);
    endproperty
    a_tx_len: assert property (p_tx_len) else $error("frame length wrong");

    property p_tx_idle;
        !st.tx_send |-> st.txd;
    endproperty
    a_tx_idle: assert property (p_tx_idle) else $error("line not idle high");

    property p_rx_arm;
        st.rx_state == asp_pkg::RX_HUNT && rx_fall && st.rx_en
            |=> st.rx_state == asp_pkg::RX_BIT && st.rx_cnt == 4'h0 && st.rx_sr == asp_pkg::RX_PRESET;
    endproperty
    a_rx_arm: assert property (p_rx_arm) else $error("start edge did not arm receiver");

    property p_rx_reject;
        st.rx_state == asp_pkg::RX_BIT && rx_roll && st.rx_sr == asp_pkg::RX_PRESET && rx_vote
            && !wr_ctrl |=> st.rx_state == asp_pkg::RX_HUNT && $stable(st.rx_done);
    endproperty
    a_rx_reject: assert property (p_rx_reject) else $error("false start not rejected");

    property p_rx_load;
        rx_load |=> st.rx_done && st.rx_buf == mirror8($past(st.rx_sr[7:0]))
            && st.rx_ninth == $past(rx_vote);
    endproperty
    a_rx_load: assert property (p_rx_load) else $error("accepted frame not stored");

    property p_rx_full;
        rx_final && st.rx_done && !wr_ctrl |=> $stable(st.rx_buf) && $stable(st.rx_ninth);
    endproperty
    a_rx_full: assert property (p_rx_full) else $error("frame stored over full buffer");

    property p_rx_stop;
        rx_final && !ten_bit |=> st.rx_state == asp_pkg::RX_STOP;
    endproperty
    a_rx_stop: assert property (p_rx_stop) else $error("stop bit time not observed");

    property p_sw_clear;
        wr_ctrl && !st.w_data[asp_pkg::CTRL_TX_DONE] && !(tx_roll && st.tx_send && st.tx_data_on)
            |=> !st.tx_done;
    endproperty
    a_sw_clear: assert property (p_sw_clear) else $error("software clear ignored");

    property p_irq;
        ($rose(st.rx_done) || $rose(st.tx_done)) && !wr_ctrl |-> serial_irq_o [*2];
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt request missing");

    c_tx_frame: cover property ($fell(st.tx_send));
    c_tx_eleven: cover property ($fell(st.tx_send) && !ten_bit);
    c_rx_accept: cover property (rx_load);
    c_rx_reject: cover property (st.rx_state == asp_pkg::RX_BIT && rx_roll && st.rx_sr == 9'h1ff
        && rx_vote);
endmodule : asp_serial_port
`default_nettype wire
